/* tmb_defines.svh */
// register offsets, field positions, reset values and timing counts for timer b control
`ifndef TMB_DEFINES_SVH
`define TMB_DEFINES_SVH

`define TMB_ADDR_PORT3_DIR 16'hff23
`define TMB_ADDR_MODE_CTRL 16'hff4e
`define TMB_ADDR_CARRIER_CTRL 16'hff4f
`define TMB_ADDR_PORT3_LATCH 16'hff03

`define TMB_RST_PORT3_DIR 8'hff
`define TMB_RST_MODE_CTRL 8'h00
`define TMB_RST_CARRIER_CTRL 8'h00
`define TMB_RST_PORT3_LATCH 8'h00
`define TMB_PORT3_DIR_UPPER 4'hf

`define TMB_BIT_RUN 7
`define TMB_BIT_OE2 6
`define TMB_CLK_HI 5
`define TMB_CLK_LO 3
`define TMB_MODE_HI 2
`define TMB_MODE_LO 1
`define TMB_BIT_OE1 0

`define TMB_BIT_REMOTE 2
`define TMB_BIT_PENDING 1
`define TMB_BIT_ACTIVE 0

`define TMB_MAIN_CLK_HZ 50000000
`define TMB_CARRIER_HZ 5000000
`define TMB_CARRIER_HALF (`TMB_MAIN_CLK_HZ / `TMB_CARRIER_HZ / 2)

`endif

/* tmb_pkg.sv */
// types for timer b control
package tmb_pkg;
    typedef enum logic [2:0] {
        TMB_CLK_MAIN = 3'h0,
        TMB_CLK_MAIN_DIV4 = 3'h1,
        TMB_CLK_EXT = 3'h2,
        TMB_CLK_EXT_DIV2 = 3'h3,
        TMB_CLK_EXT_DIV4 = 3'h4,
        TMB_CLK_EXT_DIV8 = 3'h5
    } tmb_clk_sel_type;

    typedef enum logic [2:0] {
        TMB_MODE_DISCRETE,
        TMB_MODE_CASCADE,
        TMB_MODE_CARRIER,
        TMB_MODE_DISC_PWM,
        TMB_MODE_PWM_PWM,
        TMB_MODE_PWM_DISC,
        TMB_MODE_PROHIBITED
    } tmb_mode_type;
endpackage

/* tmb_timer_b_control.sv */
// timer b mode control, carrier output control and port 3 direction
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`include "tmb_defines.svh"

module tmb_timer_b_control (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [15:0] addr,
    input wire logic [7:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [7:0] rdData,
    input wire logic [1:0] modeA,
    input wire logic timerARun,
    input wire logic matchIrqA,
    input wire logic externalCountInput,
    input wire logic matchB,
    input wire logic matchBHigh,
    input wire logic timerBOut,
    output logic countTickB,
    output logic clearCounterB,
    output logic clearCounterA,
    output logic runCounterA,
    output logic cascadeMode,
    output logic carrierMode,
    output logic [2:0] opMode,
    output logic [3:0] port3Out,
    output logic [3:0] port3Oe
);
    logic [7:0] modeCtrl_r;
    logic [2:0] carrierCtrl_r;
    logic [3:0] portDir_r;
    logic [3:0] portLatch_r;
    logic [1:0] extSync_r;
    logic extPrev_r;
    logic [2:0] extDiv_r;
    logic [1:0] mainDiv_r;
    logic [7:0] carrierCnt_r;
    logic carrierClk_r;
    logic oe1Prev_r;
    tmb_pkg::tmb_mode_type mode;
    tmb_pkg::tmb_clk_sel_type clkSel;
    logic runB;
    logic extEdge;
    logic tickNxt;
    logic remoteOut;
    logic wrMode;
    logic wrCarrier;
    logic wrDir;
    logic wrLatch;
    logic [7:0] rdNxt;

    assign wrMode = wrStrobe && addr == `TMB_ADDR_MODE_CTRL;
    assign wrCarrier = wrStrobe && addr == `TMB_ADDR_CARRIER_CTRL;
    assign wrDir = wrStrobe && addr == `TMB_ADDR_PORT3_DIR;
    assign wrLatch = wrStrobe && addr == `TMB_ADDR_PORT3_LATCH;
    assign runB = modeCtrl_r[`TMB_BIT_RUN];
    assign clkSel = tmb_pkg::tmb_clk_sel_type'(modeCtrl_r[`TMB_CLK_HI:`TMB_CLK_LO]);

    // joint mode decode from timer a and timer b mode bits
    always_comb begin
        case ({modeA, modeCtrl_r[`TMB_MODE_HI:`TMB_MODE_LO]})
            4'b0000: mode = tmb_pkg::TMB_MODE_DISCRETE;
            4'b0101: mode = tmb_pkg::TMB_MODE_CASCADE;
            4'b0011: mode = tmb_pkg::TMB_MODE_CARRIER;
            4'b0010: mode = tmb_pkg::TMB_MODE_DISC_PWM;
            4'b1010: mode = tmb_pkg::TMB_MODE_PWM_PWM;
            4'b1000: mode = tmb_pkg::TMB_MODE_PWM_DISC;
            default: mode = tmb_pkg::TMB_MODE_PROHIBITED;
        endcase
    end

    // mode control register
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            modeCtrl_r <= `TMB_RST_MODE_CTRL;
        end else if (wrMode) begin
            modeCtrl_r <= wrData;
        end
    end

    // carrier output control; active data bit loaded from pending on a timer a match in carrier mode, or written directly while OE1 is clear
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            carrierCtrl_r <= 3'h0;
        end else begin
            if (wrCarrier) begin
                carrierCtrl_r[`TMB_BIT_REMOTE] <= wrData[`TMB_BIT_REMOTE];
                carrierCtrl_r[`TMB_BIT_PENDING] <= wrData[`TMB_BIT_PENDING];
            end else if (!modeCtrl_r[`TMB_BIT_OE1] && oe1Prev_r) begin
                carrierCtrl_r[`TMB_BIT_PENDING] <= 1'b0;
            end
            if (matchIrqA && carrierMode) begin
                carrierCtrl_r[`TMB_BIT_ACTIVE] <= carrierCtrl_r[`TMB_BIT_PENDING];
            end else if (wrCarrier && !modeCtrl_r[`TMB_BIT_OE1]) begin
                carrierCtrl_r[`TMB_BIT_ACTIVE] <= wrData[`TMB_BIT_ACTIVE];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            oe1Prev_r <= 1'b0;
        end else begin
            oe1Prev_r <= modeCtrl_r[`TMB_BIT_OE1];
        end
    end

    // port 3 direction and output latch
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            portDir_r <= 4'(`TMB_RST_PORT3_DIR);
            portLatch_r <= 4'h0;
        end else begin
            if (wrDir) begin
                portDir_r <= wrData[3:0];
            end
            if (wrLatch) begin
                portLatch_r <= wrData[3:0];
            end
        end
    end

    // external input edge detect and prescalers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            extSync_r <= 2'h0;
            extPrev_r <= 1'b0;
        end else begin
            extSync_r <= {extSync_r[0], externalCountInput};
            extPrev_r <= extSync_r[1];
        end
    end
    assign extEdge = extSync_r[1] && !extPrev_r;

    always_ff @(posedge clk) begin
        if (!reset_n || !runB) begin
            extDiv_r <= 3'h0;
            mainDiv_r <= 2'h0;
        end else begin
            mainDiv_r <= mainDiv_r + 2'h1;
            if (extEdge) begin
                extDiv_r <= extDiv_r + 3'h1;
            end
        end
    end

    always_comb begin
        case (clkSel)
            tmb_pkg::TMB_CLK_MAIN: tickNxt = 1'b1;
            tmb_pkg::TMB_CLK_MAIN_DIV4: tickNxt = mainDiv_r == 2'h3;
            tmb_pkg::TMB_CLK_EXT: tickNxt = extEdge;
            tmb_pkg::TMB_CLK_EXT_DIV2: tickNxt = extEdge && extDiv_r[0];
            tmb_pkg::TMB_CLK_EXT_DIV4: tickNxt = extEdge && extDiv_r[1:0] == 2'h3;
            tmb_pkg::TMB_CLK_EXT_DIV8: tickNxt = extEdge && extDiv_r == 3'h7;
            default: tickNxt = 1'b0;
        endcase
    end

    // counter control strobes to the datapath
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            countTickB <= 1'b0;
            clearCounterB <= 1'b1;
            clearCounterA <= 1'b1;
            runCounterA <= 1'b0;
            cascadeMode <= 1'b0;
            carrierMode <= 1'b0;
            opMode <= 3'h0;
        end else begin
            countTickB <= runB && tickNxt;
            clearCounterB <= !runB
                || (mode == tmb_pkg::TMB_MODE_CARRIER && (matchB || matchBHigh));
            clearCounterA <= (mode == tmb_pkg::TMB_MODE_CASCADE) ? !runB : !timerARun;
            runCounterA <= (mode == tmb_pkg::TMB_MODE_CASCADE) ? runB : timerARun;
            cascadeMode <= mode == tmb_pkg::TMB_MODE_CASCADE;
            carrierMode <= mode == tmb_pkg::TMB_MODE_CARRIER;
            opMode <= 3'(mode);
        end
    end

    // carrier clock, stopped while active data is zero
    always_ff @(posedge clk) begin
        if (!reset_n || !carrierCtrl_r[`TMB_BIT_ACTIVE]) begin
            carrierCnt_r <= 8'h00;
            carrierClk_r <= 1'b0;
        end else if (carrierCnt_r == 8'(`TMB_CARRIER_HALF - 1)) begin
            carrierCnt_r <= 8'h00;
            carrierClk_r <= !carrierClk_r;
        end else begin
            carrierCnt_r <= carrierCnt_r + 8'h01;
        end
    end

    always_comb begin
        if (!carrierCtrl_r[`TMB_BIT_ACTIVE]) begin
            remoteOut = 1'b0;
        end else if (carrierCtrl_r[`TMB_BIT_REMOTE]) begin
            remoteOut = 1'b1;
        end else begin
            remoteOut = carrierClk_r;
        end
    end

    // pin drive: pin 2 first output, pin 3 second output, each only while the other output enable is clear
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            port3Out <= 4'h0;
            port3Oe <= 4'h0;
        end else begin
            port3Oe <= ~portDir_r;
            port3Out[1:0] <= portLatch_r[1:0];
            if (modeCtrl_r[`TMB_BIT_OE1] && !modeCtrl_r[`TMB_BIT_OE2]) begin
                port3Out[2] <= carrierMode ? remoteOut : timerBOut;
            end else begin
                port3Out[2] <= portLatch_r[2];
            end
            if (modeCtrl_r[`TMB_BIT_OE2] && !modeCtrl_r[`TMB_BIT_OE1]) begin
                port3Out[3] <= timerBOut;
            end else begin
                port3Out[3] <= portLatch_r[3];
            end
        end
    end

    // register read; carrier control is write-only and reads zero
    always_comb begin
        case (addr)
            `TMB_ADDR_MODE_CTRL: rdNxt = modeCtrl_r;
            `TMB_ADDR_PORT3_DIR: rdNxt = {`TMB_PORT3_DIR_UPPER, portDir_r};
            `TMB_ADDR_PORT3_LATCH: rdNxt = {4'h0, portLatch_r};
            default: rdNxt = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdData <= 8'h00;
        end else begin
            rdData <= rdStrobe ? rdNxt : 8'h00;
        end
    end
endmodule

/* tmb_timer_b_control_asserts.sv */
// port assertions for timer b control
`timescale 1ns/1ps
module tmb_timer_b_control_asserts (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [15:0] addr,
    input wire logic [7:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    input wire logic [7:0] rdData,
    input wire logic [1:0] modeA,
    input wire logic matchB,
    input wire logic matchBHigh,
    input wire logic countTickB,
    input wire logic clearCounterB,
    input wire logic clearCounterA,
    input wire logic runCounterA,
    input wire logic cascadeMode,
    input wire logic carrierMode,
    input wire logic [2:0] opMode,
    input wire logic [3:0] port3Oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    a_reset_state: assert property ($rose(reset_n) |-> port3Oe == 4'h0
        && opMode == 3'h0 && clearCounterB && !countTickB) else $error("reset state");
    a_wo_reads_zero: assert property ($past(rdStrobe && addr == 16'hff4f)
        |-> rdData == 8'h00) else $error("carrier read");
    a_dir_upper_ones: assert property ($past(rdStrobe && addr == 16'hff23)
        |-> rdData[7:4] == 4'hf) else $error("dir upper");
    a_dir_to_enable: assert property (wrStrobe && addr == 16'hff23
        |-> ##2 port3Oe == ~$past(wrData[3:0], 2)) else $error("dir enable");
    a_stop_clears_b: assert property (wrStrobe && addr == 16'hff4e && !wrData[7]
        |-> ##2 clearCounterB && !countTickB) else $error("stop");
    a_run_main_tick: assert property (wrStrobe && addr == 16'hff4e && wrData == 8'h80
        |-> ##2 countTickB && !clearCounterB) else $error("run");
    a_cascade_run: assert property ((wrStrobe && addr == 16'hff4e && wrData[7:1] == 7'h41
        && modeA == 2'h1) ##1 (modeA == 2'h1)[*2]
        |-> cascadeMode && runCounterA && !clearCounterA) else $error("cascade");
    a_carrier_match: assert property (carrierMode && matchB |=> clearCounterB)
        else $error("carrier clear");
    a_carrier_high: assert property (carrierMode && matchBHigh |=> clearCounterB)
        else $error("carrier high clear");
endmodule

bind tmb_timer_b_control tmb_timer_b_control_asserts u_chk (.clk, .reset_n, .addr, .wrData,
    .wrStrobe, .rdStrobe, .rdData, .modeA, .matchB, .matchBHigh, .countTickB, .clearCounterB,
    .clearCounterA, .runCounterA, .cascadeMode, .carrierMode, .opMode, .port3Oe);

/* tmb_far_side.sv */
// external count source and remote output load
`timescale 1ns/1ps
module tmb_far_side #(parameter int HALF = 4) (
    input wire logic clk,
    input wire logic pinLevel,
    input wire logic pinOe,
    output logic extIn,
    output int loadRises
);
    int ph = 0;
    logic last = 1'b0;
    initial extIn = 1'b0;
    initial loadRises = 0;
    always @(posedge clk) begin
        ph <= (ph + 1) % HALF;
        if (ph == HALF - 1) extIn <= ~extIn;
        last <= pinOe & pinLevel;
        if (pinOe & pinLevel & !last) loadRises <= loadRises + 1;
    end
endmodule

/* tb.sv */
// self-checking bench for timer b control
`timescale 1ns/1ps
`include "tmb_defines.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
    logic clk = 1'b0, reset_n = 1'b0, wrStrobe = 1'b0, rdStrobe = 1'b0, timerARun = 1'b0;
    logic matchIrqA = 1'b0, matchB = 1'b0, extIn, countTickB, clearCounterB, clearCounterA;
    logic runCounterA, cascadeMode, carrierMode;
    logic matchBHigh = 1'b0, timerBOut = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wrData = 8'h00, rdData, rv;
    logic [1:0] modeA = 2'h0;
    logic [2:0] opMode;
    logic [3:0] port3Out, port3Oe;
    int fail_count = 0, comparisons = 0, nT, nE, rises;
    logic [1:0] mA[7] = '{2'h0, 2'h1, 2'h0, 2'h0, 2'h2, 2'h2, 2'h3};
    logic [1:0] mB[7] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h2, 2'h0, 2'h3};
    logic [15:0] ra[4] = '{16'hff4e, 16'hff23, 16'hff4f, 16'h0000};
    logic [7:0] re[4] = '{8'h00, 8'hff, 8'h00, 8'h00};
    tmb_timer_b_control DUT (.clk, .reset_n, .addr, .wrData, .wrStrobe, .rdStrobe, .rdData,
        .modeA, .timerARun, .matchIrqA, .externalCountInput(extIn), .matchB,
        .matchBHigh, .timerBOut, .countTickB, .clearCounterB, .clearCounterA,
        .runCounterA, .cascadeMode, .carrierMode, .opMode, .port3Out, .port3Oe);
    tmb_far_side #(.HALF(4)) u_far (.clk, .pinLevel(port3Out[2]), .pinOe(port3Oe[2]),
        .extIn, .loadRises(rises));
    always #10 clk = ~clk;
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge clk);
        wrStrobe <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [15:0] a);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge clk);
        rdStrobe <= 1'b0;
        #1 rv = rdData;
    endtask
    task automatic cnt(input int cyc);
        nT = 0;
        nE = rises;
        repeat (cyc) begin
            @(posedge clk);
            #1 nT += countTickB;
        end
        nE = rises - nE;
    endtask
    task automatic pulse();
        matchIrqA <= 1'b1;
        matchB <= 1'b1;
        @(posedge clk);
        matchIrqA <= 1'b0;
        matchB <= 1'b0;
        cnt(3);
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1 `CHK("oe", 4'h0, port3Oe)
        for (int i = 0; i < 4; i++) begin
            rd(ra[i]);
            `CHK("rd", re[i], rv)
        end
        wr(16'hff23, 8'h02);
        rd(16'hff23);
        `CHK("dir", 8'hf2, rv)
        `CHK("oe", 4'hd, port3Oe)
        for (int i = 0; i < 6; i++) begin
            wr(16'hff4e, 8'h00);
            wr(16'hff4e, {2'b10, i[2:0], 3'b000});
            cnt(256);
            `CHK("tick", 1'b1, (nT - (256 >> (i == 0 ? 0 : i + 1))) inside {[-1:1]})
        end
        wr(16'hff4e, 8'h00);
        `CHK("stop", 2'b10, {clearCounterB, countTickB})
        for (int i = 0; i < 7; i++) begin
            modeA <= mA[i];
            wr(16'hff4e, {5'h00, mB[i], 1'b0});
            `CHK("mode", i[2:0], opMode)
        end
        modeA <= 2'h1;
        wr(16'hff4e, 8'h82);
        `CHK("casc", 3'b110, {cascadeMode, runCounterA, clearCounterA})
        timerARun <= 1'b1;
        wr(16'hff4e, 8'h02);
        `CHK("casc", 3'b011, {runCounterA, clearCounterA, clearCounterB})
        modeA <= 2'h0;
        wr(16'hff4e, 8'h06);
        wr(16'hff4f, 8'h03);
        wr(16'hff4e, 8'h87);
        cnt(100);
        `CHK("pulses", 1'b1, (nE - 100 / (2 * `TMB_CARRIER_HALF)) inside {[-1:1]})
        wr(16'hff4f, 8'h06);
        cnt(10);
        cnt(50);
        `CHK("steady", 2'b10, {port3Out[2], nE != 0})
        wr(16'hff4f, 8'h04);
        pulse();
        `CHK("pin", 1'b0, port3Out[2])
        wr(16'hff4f, 8'h06);
        pulse();
        `CHK("pin", 1'b1, port3Out[2])
        matchBHigh <= 1'b1;
        @(posedge clk);
        matchBHigh <= 1'b0;
        #1 `CHK("hclr", 1'b1, clearCounterB)
        @(posedge clk);
        #1;
        wr(16'hff4e, 8'h06);
        wr(16'hff03, 8'h04);
        `CHK("latch", 1'b1, port3Out[2])
        timerBOut <= 1'b1;
        wr(16'hff4e, 8'h40);
        `CHK("pin3", 1'b1, port3Out[3])
        wr(16'hff4e, 8'h41);
        `CHK("both", 2'b01, port3Out[3:2])
        wr(16'hff4e, 8'h87);
        pulse();
        `CHK("pend", 1'b0, port3Out[2])
        test_done();
    end
endmodule
